// file: hw/blit_fill_pkg.sv
// Register map, field positions and state encoding of the blit fill stage
package blit_fill_pkg;
	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SIZE = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	localparam logic [7:0] OFS_IRQ  = 8'h0c;
	localparam logic [7:0] OFS_MASK = 8'h10;
	localparam logic [7:0] OFS_APTR = 8'h14;
	localparam logic [7:0] OFS_AMOD = 8'h18;
	localparam logic [7:0] OFS_DPTR = 8'h1c;
	localparam logic [7:0] OFS_DMOD = 8'h20;
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int BIT_DESC  = 1;
	localparam int BIT_FCI   = 2;
	localparam int BIT_INCL  = 3;
	localparam int BIT_EXCL  = 4;
	localparam int SZ_W_LSB  = 0;
	localparam int SZ_W_BITS = 6;
	localparam int SZ_H_LSB  = 6;
	localparam int SZ_H_BITS = 10;
	localparam int STAT_BUSY = 0;
	localparam int IRQ_DONE  = 0;
	// ------------------------------------------------------------
	// Reset values and step
	// ------------------------------------------------------------
	localparam logic [15:0] CTRL_RST  = 16'h0000;
	localparam logic [15:0] MOD_RST   = 16'h0000;
	localparam logic [15:0] WORD_STEP = 16'h0002;
	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_RUN  = 1'b1
	} run_state_t;
endpackage

// file: hw/blit_area_fill.sv
// Blit area-fill stage with busy flag, pointers and AHB-Lite registers
// Behaviour
// - Control bit 3 enables inclusive fill, bit 4 exclusive fill.
// - Inclusive fill sets pixels between boundaries and keeps boundaries.
// - Exclusive fill drops the left boundary of each filled span.
// - Fill acts on the combined result, after shift, mask and logic.
// - Fill always works on whole 16-bit words.
// - Carry-in one fills outside the boundaries, inside stays zero.
// - Fill state loads from carry-in at each row's rightmost word.
// - Each one bit toggles fill state; state gives written pixel.
// - Fill state carries leftward across words and stops at row end.
// - Writing the size register starts the blit.
// - The engine never stalls the processor.
// - Busy flag in status register reads set while blit runs.
// - Each channel's modulo is applied to its pointer at row end.
// - Control bit 1 selects descending: pointers minus two, modulos subtracted.
module blit_area_fill #(
	parameter int AW = 24
) (
	// Clock and reset
	input  wire logic          hclk,
	input  wire logic          hresetn,
	// AHB-Lite slave
	input  wire logic          hsel,
	input  wire logic [31:0]   haddr,
	input  wire logic [1:0]    htrans,
	input  wire logic          hwrite,
	input  wire logic [2:0]    hsize,
	input  wire logic [31:0]   hwdata,
	input  wire logic          hready,
	output logic               hreadyout,
	output logic               hresp,
	output logic [31:0]        hrdata,
	// Combined source words, rightmost word of a row first
	input  wire logic          src_valid,
	input  wire logic [15:0]   src_data,
	output logic               src_ready,
	output logic [AW-1:0]      a_addr,
	// Destination words
	output logic               dst_valid,
	output logic [15:0]        dst_data,
	output logic [AW-1:0]      dst_addr,
	input  wire logic          dst_ready,
	// Interrupt
	output logic               irq
);
	localparam int WW = blit_fill_pkg::SZ_W_BITS;
	localparam int HW = blit_fill_pkg::SZ_H_BITS;

	blit_fill_pkg::run_state_t state, next_state;
	logic [15:0]   ctrl, next_ctrl;
	logic [WW:0]   width, next_width, col, next_col;
	logic [HW:0]   row, next_row;
	logic          first, next_first, in_pend, next_in_pend;
	logic          carry, next_carry;
	logic          out_valid, next_out_valid, out_last, next_out_last;
	logic          out_rend, next_out_rend;
	logic [15:0]   out_data, next_out_data;
	logic [AW-1:0] a_ptr, next_a_ptr, d_ptr, next_d_ptr;
	logic [15:0]   a_mod, next_a_mod, d_mod, next_d_mod;
	logic          irq_st, next_irq_st, irq_mask, next_irq_mask;
	logic [31:0]   rdata, next_rdata;
	logic          ap_valid, next_ap_valid, ap_write, next_ap_write;
	logic [7:0]    ap_addr, next_ap_addr;
	logic          fill_on, take, dst_take, wr, desc, fin;
	logic [16:0]   fres;
	logic [WW-1:0] wf;
	logic [HW-1:0] hf;

	// ------------------------------------------------------------
	// Fill of one word, bit 0 first; returns {carry, word}
	// ------------------------------------------------------------
	function automatic logic [16:0] fill_word(input logic [15:0] d, input logic c,
			input logic incl, input logic excl);
		logic        s;
		logic [15:0] o;
		s = c;
		o = d;
		for (int i = 0; i < 16; i++) begin
			if (incl) begin
				o[i] = d[i] | s;
			end
			s = s ^ d[i];
			if (excl && !incl) begin
				o[i] = s;
			end
		end
		return {s, o};
	endfunction

	// ------------------------------------------------------------
	// Pointer step, modulo added only at row end
	// ------------------------------------------------------------
	function automatic logic [AW-1:0] ptr_step(input logic [AW-1:0] p, input logic [15:0] m,
			input logic rend, input logic dn);
		logic [AW-1:0] st;
		st = AW'(blit_fill_pkg::WORD_STEP);
		if (rend) begin
			st = st + {{(AW-16){m[15]}}, m};
		end
		return dn ? p - st : p + st;
	endfunction

	// ------------------------------------------------------------
	// Datapath and control
	// ------------------------------------------------------------
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdata;
	assign a_addr    = a_ptr;
	assign dst_addr  = d_ptr;
	assign dst_valid = out_valid;
	assign dst_data  = out_data;
	assign irq       = irq_st & irq_mask;
	assign desc      = ctrl[blit_fill_pkg::BIT_DESC];
	assign fill_on   = ctrl[blit_fill_pkg::BIT_INCL] | ctrl[blit_fill_pkg::BIT_EXCL];
	// Output stage stalls the input when the destination holds off
	assign src_ready = (state == blit_fill_pkg::ST_RUN) && in_pend && (!out_valid || dst_ready);
	assign take      = src_valid && src_ready;
	assign dst_take  = out_valid && dst_ready;
	assign fin       = dst_take && out_last;
	assign wr        = ap_valid && ap_write;
	assign wf        = hwdata[blit_fill_pkg::SZ_W_LSB +: WW];
	assign hf        = hwdata[blit_fill_pkg::SZ_H_LSB +: HW];
	// Whole word always goes through, carry reloads on a row's first word
	assign fres = fill_word(src_data, first ? ctrl[blit_fill_pkg::BIT_FCI] : carry,
		ctrl[blit_fill_pkg::BIT_INCL], ctrl[blit_fill_pkg::BIT_EXCL]);

	always_comb begin
		next_state     = state;
		next_ctrl      = ctrl;
		next_width     = width;
		next_col       = col;
		next_row       = row;
		next_first     = first;
		next_in_pend   = in_pend;
		next_carry     = carry;
		next_out_valid = out_valid;
		next_out_last  = out_last;
		next_out_rend  = out_rend;
		next_out_data  = out_data;
		next_a_ptr     = a_ptr;
		next_d_ptr     = d_ptr;
		next_a_mod     = a_mod;
		next_d_mod     = d_mod;
		next_irq_st    = irq_st;
		next_irq_mask  = irq_mask;
		next_rdata     = rdata;
		next_ap_valid  = hsel && htrans[1] && hready;
		next_ap_write  = hwrite;
		next_ap_addr   = haddr[7:0];
		if (!(hsel && htrans[1] && hready)) begin
			next_ap_write = 1'b0;
			next_ap_addr  = ap_addr;
		end
		// Read data registered in the address phase
		if (hsel && htrans[1] && hready && !hwrite) begin
			case (haddr[7:0])
				blit_fill_pkg::OFS_CTRL: next_rdata = {16'h0000, ctrl};
				blit_fill_pkg::OFS_STAT: next_rdata = {31'h0, state == blit_fill_pkg::ST_RUN};
				blit_fill_pkg::OFS_IRQ:  next_rdata = {31'h0, irq_st};
				blit_fill_pkg::OFS_MASK: next_rdata = {31'h0, irq_mask};
				blit_fill_pkg::OFS_APTR: next_rdata = {{(32-AW){1'b0}}, a_ptr};
				blit_fill_pkg::OFS_AMOD: next_rdata = {16'h0000, a_mod};
				blit_fill_pkg::OFS_DPTR: next_rdata = {{(32-AW){1'b0}}, d_ptr};
				blit_fill_pkg::OFS_DMOD: next_rdata = {16'h0000, d_mod};
				default:                 next_rdata = 32'h0000_0000;
			endcase
		end
		// Writes; setup registers should not change during a blit
		if (wr) begin
			case (ap_addr)
				blit_fill_pkg::OFS_CTRL: next_ctrl = hwdata[15:0];
				blit_fill_pkg::OFS_MASK: next_irq_mask = hwdata[blit_fill_pkg::IRQ_DONE];
				blit_fill_pkg::OFS_APTR: next_a_ptr = hwdata[AW-1:0];
				blit_fill_pkg::OFS_AMOD: next_a_mod = hwdata[15:0];
				blit_fill_pkg::OFS_DPTR: next_d_ptr = hwdata[AW-1:0];
				blit_fill_pkg::OFS_DMOD: next_d_mod = hwdata[15:0];
				blit_fill_pkg::OFS_IRQ:
					if (hwdata[blit_fill_pkg::IRQ_DONE]) begin
						next_irq_st = 1'b0;
					end
				blit_fill_pkg::OFS_SIZE:
					if (state == blit_fill_pkg::ST_IDLE) begin
						next_state   = blit_fill_pkg::ST_RUN;
						next_width   = {wf == '0, wf};
						next_col     = {wf == '0, wf};
						next_row     = {hf == '0, hf};
						next_first   = 1'b1;
						next_in_pend = 1'b1;
					end
				default: ;
			endcase
		end
		// Input word into the output stage
		if (take) begin
			next_out_valid = 1'b1;
			next_out_data  = fill_on ? fres[15:0] : src_data;
			next_carry     = fres[16];
			next_out_rend  = (col == 1);
			next_out_last  = (col == 1) && (row == 1);
			next_a_ptr     = ptr_step(a_ptr, a_mod, col == 1, desc);
			next_first     = (col == 1);
			if (col == 1) begin
				next_col = width;
				next_row = row - 1'b1;
				if (row == 1) begin
					next_in_pend = 1'b0;
				end
			end else begin
				next_col = col - 1'b1;
			end
		end else if (dst_take) begin
			next_out_valid = 1'b0;
		end
		if (dst_take) begin
			next_d_ptr = ptr_step(d_ptr, d_mod, out_rend, desc);
		end
		if (fin) begin
			next_state  = blit_fill_pkg::ST_IDLE;
			next_irq_st = 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state     <= blit_fill_pkg::ST_IDLE;
			ctrl      <= blit_fill_pkg::CTRL_RST;
			width     <= '0;
			col       <= '0;
			row       <= '0;
			first     <= 1'b1;
			in_pend   <= 1'b0;
			carry     <= 1'b0;
			out_valid <= 1'b0;
			out_last  <= 1'b0;
			out_rend  <= 1'b0;
			out_data  <= 16'h0000;
			a_ptr     <= '0;
			d_ptr     <= '0;
			a_mod     <= blit_fill_pkg::MOD_RST;
			d_mod     <= blit_fill_pkg::MOD_RST;
			irq_st    <= 1'b0;
			irq_mask  <= 1'b0;
			rdata     <= 32'h0000_0000;
			ap_valid  <= 1'b0;
			ap_write  <= 1'b0;
			ap_addr   <= 8'h00;
		end else begin
			state     <= next_state;
			ctrl      <= next_ctrl;
			width     <= next_width;
			col       <= next_col;
			row       <= next_row;
			first     <= next_first;
			in_pend   <= next_in_pend;
			carry     <= next_carry;
			out_valid <= next_out_valid;
			out_last  <= next_out_last;
			out_rend  <= next_out_rend;
			out_data  <= next_out_data;
			a_ptr     <= next_a_ptr;
			d_ptr     <= next_d_ptr;
			a_mod     <= next_a_mod;
			d_mod     <= next_d_mod;
			irq_st    <= next_irq_st;
			irq_mask  <= next_irq_mask;
			rdata     <= next_rdata;
			ap_valid  <= next_ap_valid;
			ap_write  <= next_ap_write;
			ap_addr   <= next_ap_addr;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_start;
		wr && ap_addr == blit_fill_pkg::OFS_SIZE && state == blit_fill_pkg::ST_IDLE
			|=> state == blit_fill_pkg::ST_RUN ##1 src_ready || !src_valid || out_valid;
	endproperty
	a_start: assert property (p_start) else $error("size write did not start");

	property p_busy_read;
		hsel && htrans[1] && hready && !hwrite && haddr[7:0] == blit_fill_pkg::OFS_STAT
			|=> hrdata[blit_fill_pkg::STAT_BUSY] == ($past(state) == blit_fill_pkg::ST_RUN);
	endproperty
	a_busy_read: assert property (p_busy_read) else $error("busy flag wrong");

	property p_no_stall;
		hreadyout && !hresp;
	endproperty
	a_no_stall: assert property (p_no_stall) else $error("bus stalled");

	property p_done;
		fin |=> state == blit_fill_pkg::ST_IDLE && irq_st ##1 !src_ready || $past(wr);
	endproperty
	a_done: assert property (p_done) else $error("busy not cleared");

	property p_pass;
		take && !fill_on |=> out_data == $past(src_data) && out_valid;
	endproperty
	a_pass: assert property (p_pass) else $error("fill off altered data");

	property p_incl_keep;
		take && ctrl[blit_fill_pkg::BIT_INCL]
			|=> (out_data & $past(src_data)) == $past(src_data);
	endproperty
	a_incl_keep: assert property (p_incl_keep) else $error("boundary lost");

	property p_carry_in;
		take && fill_on && first && ctrl[blit_fill_pkg::BIT_FCI] && src_data == 16'h0000
			|=> out_data == 16'hffff;
	endproperty
	a_carry_in: assert property (p_carry_in) else $error("carry-in fill wrong");

	property p_excl_left;
		take && ctrl[blit_fill_pkg::BIT_EXCL] && !ctrl[blit_fill_pkg::BIT_INCL] && first
			&& !ctrl[blit_fill_pkg::BIT_FCI] && src_data == 16'h0001 |=> out_data == 16'hffff;
	endproperty
	a_excl_left: assert property (p_excl_left) else $error("exclusive fill wrong");

	property p_carry_across;
		take && !first && carry && fill_on && src_data == 16'h0000 |=> out_data == 16'hffff;
	endproperty
	a_carry_across: assert property (p_carry_across) else $error("carry not kept");

	c_fill_blit: cover property (take && fill_on && desc ##[1:50] fin);
	c_stall: cover property (out_valid && !dst_ready && src_valid);
	c_row_end: cover property (dst_take && out_rend && !out_last);
endmodule

// file: bench/blit_mem_model.sv
// Far-side model: source word feed and destination word sink
module blit_mem_model #(
	parameter int AW = 24
) (
	// Clock and reset
	input  wire logic          hclk,
	input  wire logic          hresetn,
	// Source words
	output logic               src_valid,
	output logic [15:0]        src_data,
	input  wire logic          src_ready,
	input  wire logic [AW-1:0] a_addr,
	// Destination words
	input  wire logic          dst_valid,
	input  wire logic [15:0]   dst_data,
	input  wire logic [AW-1:0] dst_addr,
	output logic               dst_ready,
	// Scenario control
	input  wire logic [15:0]   pattern,
	input  wire logic          stall
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0]   got_d[$];
	logic [AW-1:0] got_da[$];
	logic [AW-1:0] got_aa[$];
	// Idle line shows the inverse, so stale data never passes for fresh
	assign src_data = src_valid ? pattern : ~pattern;
	// Slow sink toggles ready, which also throttles the source side
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			src_valid <= 1'b0;
			dst_ready <= 1'b0;
		end else begin
			src_valid <= 1'b1;
			dst_ready <= stall ? ~dst_ready : 1'b1;
			if (src_valid && src_ready)
				got_aa.push_back(a_addr);
			if (dst_valid && dst_ready) begin
				got_d.push_back(dst_data);
				got_da.push_back(dst_addr);
			end
		end
	end
endmodule

// file: bench/blit_area_fill_bench.sv
// Self-checking bench: fill modes, pointers, busy flag and interrupt
module blit_area_fill_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int AW = 24;
	logic          hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, stall;
	logic          src_valid, src_ready, dst_valid, dst_ready;
	logic [1:0]    htrans;
	logic [2:0]    hsize;
	logic [31:0]   haddr, hwdata, hrdata, q;
	logic [15:0]   src_data, dst_data, pattern;
	logic [AW-1:0] a_addr, dst_addr;
	int            fail_count, num_checks, n;
	logic [15:0]   modes[7] = '{16'h000a, 16'h0012, 16'h000e, 16'h0016, 16'h001a, 16'h0002, 16'h0000};
	logic [15:0]   pats[4]  = '{16'h2410, 16'h0810, 16'h0000, 16'h0001};
	assign hready = hreadyout;
	always #20 hclk = ~hclk;
	blit_area_fill #(.AW(AW)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .src_valid(src_valid), .src_data(src_data), .src_ready(src_ready), .a_addr(a_addr),
		.dst_valid(dst_valid), .dst_data(dst_data), .dst_addr(dst_addr), .dst_ready(dst_ready), .irq(irq));
	blit_mem_model #(.AW(AW)) mem (.hclk(hclk), .hresetn(hresetn), .src_valid(src_valid), .src_data(src_data),
		.src_ready(src_ready), .a_addr(a_addr), .dst_valid(dst_valid), .dst_data(dst_data), .dst_addr(dst_addr),
		.dst_ready(dst_ready), .pattern(pattern), .stall(stall));
	// ------------------------------------------------------------
	// Bus cycles and comparison
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= wr;
		hsize <= 3'h2;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		q = hrdata;
	endtask
	task automatic irq_is(input logic exp);
		@(negedge hclk);
		chk(32'(irq), 32'(exp));
		@(posedge hclk);
	endtask
	// Output bit is pixel or state before toggle when inclusive, state after toggle when exclusive
	function automatic logic [15:0] fill_word(input logic [15:0] w, input logic [15:0] c, inout logic st);
		logic [15:0] o;
		for (int i = 0; i < 16; i++) begin
			o[i] = w[i] | st;
			st = st ^ w[i];
			if (!c[blit_fill_pkg::BIT_INCL])
				o[i] = c[blit_fill_pkg::BIT_EXCL] ? st : w[i];
		end
		return o;
	endfunction
	// Two rows of two words; A modulo of minus one row refetches the same row
	task automatic blit(input logic [15:0] c, input logic [15:0] pat);
		logic          st;
		logic          dn;
		logic [AW-1:0] da;
		dn = c[blit_fill_pkg::BIT_DESC];
		pattern <= pat;
		mem.got_d.delete();
		mem.got_da.delete();
		mem.got_aa.delete();
		bus(1'b1, blit_fill_pkg::OFS_CTRL, {16'h0, c});
		bus(1'b1, blit_fill_pkg::OFS_DPTR, 32'h1000);
		bus(1'b1, blit_fill_pkg::OFS_DMOD, 32'h0004);
		bus(1'b1, blit_fill_pkg::OFS_APTR, 32'h2000);
		bus(1'b1, blit_fill_pkg::OFS_AMOD, 32'hfffc);
		bus(1'b1, blit_fill_pkg::OFS_SIZE, 32'h0082);
		n = 0;
		while (mem.got_d.size() < 4 && n < 300) begin
			@(posedge hclk);
			n++;
		end
		chk(32'(mem.got_d.size()), 32'd4);
		da = 24'h1000;
		for (int r = 0; r < 2; r++) begin
			st = c[blit_fill_pkg::BIT_FCI];
			for (int k = 0; k < 2; k++) begin
				chk(32'(mem.got_d[r*2+k]), 32'(fill_word(pat, c, st)));
				chk(32'(mem.got_da[r*2+k]), 32'(da));
				chk(32'(mem.got_aa[r*2+k]), dn ? 32'h1ffe + 32'(2*(1-k)) : 32'h2000 + 32'(2*k));
				da = dn ? da - 24'h2 : da + 24'h2;
			end
			da = dn ? da - 24'h4 : da + 24'h4;
		end
	endtask
	task automatic stop_test;
		$display("Checks %0d, mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ------------------------------------------------------------
	// Test sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		repeat (6000) @(posedge hclk);
		fail_count++;
		stop_test();
	end
	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		pattern = 16'h0;
		stall = 1'b0;
		fail_count = 0;
		num_checks = 0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk(32'(hresp), 32'h0);
		bus(1'b0, blit_fill_pkg::OFS_CTRL, 32'h0);
		chk(q, {16'h0, blit_fill_pkg::CTRL_RST});
		bus(1'b1, 8'h24, 32'hffffffff);
		bus(1'b0, 8'h24, 32'h0);
		chk(q, 32'h0);
		bus(1'b0, blit_fill_pkg::OFS_STAT, 32'h0);
		chk(q, 32'h0);
		// Slow sink keeps the engine busy; a second start must be ignored
		stall <= 1'b1;
		bus(1'b1, blit_fill_pkg::OFS_SIZE, 32'h0084);
		bus(1'b0, blit_fill_pkg::OFS_STAT, 32'h0);
		chk(32'(q[0]), 32'h1);
		chk(32'(hreadyout), 32'h1);
		bus(1'b1, blit_fill_pkg::OFS_SIZE, 32'h0084);
		n = 0;
		while (q[0] !== 1'b0 && n < 200) begin
			bus(1'b0, blit_fill_pkg::OFS_STAT, 32'h0);
			n++;
		end
		chk(32'(q[0]), 32'h0);
		chk(32'(mem.got_d.size()), 32'd8);
		bus(1'b0, blit_fill_pkg::OFS_IRQ, 32'h0);
		chk(q, 32'h1);
		irq_is(1'b0);
		bus(1'b1, blit_fill_pkg::OFS_MASK, 32'h1);
		irq_is(1'b1);
		bus(1'b1, blit_fill_pkg::OFS_IRQ, 32'h1);
		irq_is(1'b0);
		stall <= 1'b0;
		for (int m = 0; m < 7; m++) begin
			for (int p = 0; p < 4; p++) begin
				blit(modes[m], pats[p]);
				bus(1'b0, blit_fill_pkg::OFS_STAT, 32'h0);
				chk(q, 32'h0);
			end
		end
		stop_test();
	end
endmodule
